// ===== include/spi_pkg.sv
package spi_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int SYNC_W = 4;

	// register byte offsets
	localparam logic [AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_MR = 8'h04;
	localparam logic [AW-1:0] OFF_RDR = 8'h08;
	localparam logic [AW-1:0] OFF_TDR = 8'h0c;
	localparam logic [AW-1:0] OFF_SR = 8'h10;
	localparam logic [AW-1:0] OFF_IER = 8'h14;
	localparam logic [AW-1:0] OFF_IDR = 8'h18;
	localparam logic [AW-1:0] OFF_IMR = 8'h1c;
	localparam logic [AW-1:0] OFF_RPR = 8'h20;
	localparam logic [AW-1:0] OFF_RCR = 8'h24;
	localparam logic [AW-1:0] OFF_TPR = 8'h28;
	localparam logic [AW-1:0] OFF_TCR = 8'h2c;
	localparam logic [AW-1:0] OFF_CSR0 = 8'h30;
	localparam logic [AW-1:0] CSR_BANK_MASK = 8'hf0;
	localparam logic [AW-1:0] WORD_MASK = 8'hfc;

	// control register
	localparam int CR_EN = 0;
	localparam int CR_DIS = 1;
	// mode register
	localparam int MR_MASTER_SELECT = 0;
	localparam int MR_PS = 1;
	localparam int MR_DEC = 2;
	localparam int MR_DIV = 3;
	localparam int MR_LLB = 7;
	localparam int MR_PCS_LO = 16;
	localparam int MR_GAP_LO = 24;
	// transmit / receive words
	localparam int TD_PCS_LO = 16;
	localparam int DATA_W = 16;
	// chip select configuration
	localparam int CSR_POL = 0;
	localparam int CSR_PHA = 1;
	localparam int CSR_BITS_LO = 4;
	localparam int CSR_BAUD_LO = 8;
	localparam int CSR_LEAD_LO = 16;
	localparam int CSR_IW_LO = 24;
	// status bits
	localparam int SR_RXF = 0;
	localparam int SR_TXE = 1;
	localparam int SR_MODE_FAULT = 2;
	localparam int SR_OVR = 3;
	localparam int SR_RXD = 4;
	localparam int SR_TXD = 5;
	localparam int SR_EN = 16;
	localparam int NSRC = 6;

	localparam logic [4:0] DIV32_LAST = 5'h1f;
	localparam logic [4:0] BITS_BASE = 5'h08;
	localparam logic [4:0] DATA_W5 = 5'h10;
	localparam logic [7:0] MIN_GAP = 8'h06;
	localparam logic [7:0] BAUD_MIN = 8'h02;
	localparam logic [13:0] IW_ZERO = 14'h0004;
	localparam int IW_SHIFT = 5;
	localparam logic [31:0] PTR_STEP = 32'h0000_0002;
	localparam logic [3:0] CS_IDLE = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_GAP = 5'b00010,
		S_LEAD = 5'b00100,
		S_XFER = 5'b01000,
		S_TAIL = 5'b10000
	} mst_state_e;
endpackage

// ===== src/spi_sync2.sv
`timescale 1ns/10ps
module spi_sync2 (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [spi_pkg::SYNC_W-1:0] d_i,
	output logic [spi_pkg::SYNC_W-1:0] q_o
);
	import spi_pkg::*;

	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] q_r;

	// first stage is read only by the second
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= '1;
			q_r <= '1;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule

// ===== src/spi_ctrl.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - master mode when master_select is 1, slave when 0
// - select_decode 1 drives encoded selects for an external decoder
// - decoded: config register k governs selects 4k to 4k+3
// - serial logic runs at full clock or clock divided by 32
// - loopback feeds serializer output back to its input in master mode
// - undecoded select code maps to one low line, 1111 to none; decoded passes code
// - variable select takes the select code from each transmit word
// - gap between selects is programmed periods, at least six
// - received word right-justified, upper data bits read zero
// - select lines captured into receive word in master mode only
// - rx_full set on receive load, cleared by reading it
// - tx_empty low at reset, disabled, after write; enable sets it
// - mode_fault stays set until status register is read
// - second receive load without read sets overrun; status read clears
// - block-done flags show both channels' end signals
// - enable register sets mask bits, disable clears, view reads them
// - channel count zero stops it, nonzero moves on trigger flag
// - serial clock idles at the clock_idle_level value
// - phase selects change-then-sample or sample-then-change edges
// - serial clock is master clock over twice divider; below 2 stops
// - lead delay is half a clock period when zero, else field periods
// - inter-word delay is four periods when zero, else 32 times field
// - external low on slave select in master mode faults and disables
// - each channel move decrements count, increments pointer
module spi_ctrl (
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic [spi_pkg::AW-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [spi_pkg::DW-1:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [spi_pkg::AW-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [spi_pkg::DW-1:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic SERIAL_CLOCK_LINE_I,
	output logic SERIAL_CLOCK_LINE_O,
	output logic SERIAL_CLOCK_LINE_OE_O,
	input wire logic MOSI_I,
	output logic MOSI_O,
	output logic MOSI_OE_O,
	input wire logic MISO_I,
	output logic MISO_O,
	output logic MISO_OE_O,
	input wire logic NSS_I,
	output logic [3:0] CS_O,
	output logic CS_OE_O,
	output logic RX_REQ_O,
	input wire logic RX_ACK_I,
	output logic [spi_pkg::DW-1:0] RX_DATA_O,
	output logic [spi_pkg::DW-1:0] RX_ADDR_O,
	output logic TX_REQ_O,
	input wire logic TX_ACK_I,
	input wire logic [spi_pkg::DW-1:0] TX_DATA_I,
	output logic [spi_pkg::DW-1:0] TX_ADDR_O,
	output logic IRQ_O
);
	import spi_pkg::*;

	typedef struct packed {
		logic en;
		logic dis_pend;
		logic [31:0] mr;
		logic [3:0][31:0] csr;
		logic [31:0] rdr;
		logic [31:0] tdr;
		logic rxf;
		logic txe;
		logic mode_fault;
		logic ovr;
		logic [NSRC-1:0] imr;
		logic [31:0] rpr;
		logic [15:0] rcr;
		logic [31:0] tpr;
		logic [15:0] tcr;
		mst_state_e st;
		logic [4:0] div;
		logic [13:0] dly;
		logic [7:0] hcnt;
		logic [5:0] edges;
		logic [15:0] tsh;
		logic [15:0] rsh;
		logic sclk;
		logic [3:0] cs;
		logic [3:0] cur;
		logic [31:0] cfg;
		logic nss_q;
		logic sck_q;
		logic awv;
		logic wv;
		logic [AW-1:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] bresp;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rresp;
	} core_s;

	core_s st_r;
	core_s st_nxt;
	logic [SYNC_W-1:0] sy;
	logic nss_s;
	logic sck_s;
	logic mosi_s;
	logic miso_s;
	logic [31:0] sr_v;
	logic [3:0] tgt_code;
	logic [3:0] tgt_lines;
	logic [31:0] tgt_cfg;
	logic [7:0] tgt_baud;
	logic tgt_ok;
	logic [31:0] cfg_a;
	logic [4:0] nb;
	logic mtick;
	logic dly_end;
	logic edge_ev;
	logic din;
	logic lead_e;
	logic samp;
	logic [31:0] wdat;
	logic [7:0] lead_f;
	logic [7:0] iw_f;
	logic [7:0] gap_f;

	spi_sync2 u_sync (
		.clk_i(REF_CLK_I),
		.rst_b_i(RST_B_I),
		.d_i({NSS_I, SERIAL_CLOCK_LINE_I, MOSI_I, MISO_I}),
		.q_o(sy)
	);
	assign nss_s = sy[3];
	assign sck_s = sy[2];
	assign mosi_s = sy[1];
	assign miso_s = sy[0];

	// undecoded: first zero bit picks the line; 1111 selects nothing
	function automatic logic [3:0] cs_lines(input logic [3:0] code,
			input logic dec);
		if (dec)
			return code;
		if (!code[0])
			return 4'he;
		if (!code[1])
			return 4'hd;
		if (!code[2])
			return 4'hb;
		if (!code[3])
			return 4'h7;
		return CS_IDLE;
	endfunction

	function automatic logic [1:0] csr_idx(input logic [3:0] code,
			input logic dec);
		if (dec)
			return code[3:2];
		if (!code[0])
			return 2'h0;
		if (!code[1])
			return 2'h1;
		if (!code[2])
			return 2'h2;
		return 2'h3;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction

	function automatic core_s store_word(input core_s c,
			input logic [3:0] peripheral_select_code);
		core_s r;
		r = c;
		r.rdr = '0;
		r.rdr[DATA_W-1:0] = c.rsh;
		r.rdr[TD_PCS_LO +: 4] = peripheral_select_code;
		if (c.rxf)
			r.ovr = 1'b1;
		r.rxf = 1'b1;
		return r;
	endfunction

	function automatic core_s load_word(input core_s c,
			input logic [4:0] bits);
		core_s r;
		r = c;
		r.tsh = c.tdr[DATA_W-1:0] << (DATA_W5 - bits);
		r.rsh = '0;
		r.txe = 1'b1;
		r.edges = '0;
		return r;
	endfunction

	always_comb begin
		sr_v = '0;
		sr_v[SR_RXF] = st_r.rxf;
		sr_v[SR_TXE] = st_r.txe;
		sr_v[SR_MODE_FAULT] = st_r.mode_fault;
		sr_v[SR_OVR] = st_r.ovr;
		sr_v[SR_RXD] = st_r.rcr == '0;
		sr_v[SR_TXD] = st_r.tcr == '0;
		sr_v[SR_EN] = st_r.en;
	end

	assign tgt_code = st_r.mr[MR_PS] ? st_r.tdr[TD_PCS_LO +: 4]
		: st_r.mr[MR_PCS_LO +: 4];
	assign tgt_lines = cs_lines(tgt_code, st_r.mr[MR_DEC]);
	assign tgt_cfg = st_r.csr[csr_idx(tgt_code, st_r.mr[MR_DEC])];
	assign tgt_baud = tgt_cfg[CSR_BAUD_LO +: 8];
	assign tgt_ok = tgt_baud >= BAUD_MIN;
	// slave mode always takes its format from the first register
	assign cfg_a = st_r.mr[MR_MASTER_SELECT] ? st_r.cfg : st_r.csr[0];
	assign nb = BITS_BASE + 5'(cfg_a[CSR_BITS_LO +: 4]);
	assign lead_f = st_r.cfg[CSR_LEAD_LO +: 8];
	assign iw_f = st_r.cfg[CSR_IW_LO +: 8];
	assign gap_f = st_r.mr[MR_GAP_LO +: 8];
	assign mtick = !st_r.mr[MR_DIV] || st_r.div == DIV32_LAST;
	assign dly_end = mtick && st_r.dly <= 14'h0001;
	assign wdat = merge('0, st_r.wd, st_r.ws);

	always_comb begin
		st_nxt = st_r;
		edge_ev = 1'b0;
		lead_e = 1'b0;
		samp = 1'b0;
		din = mosi_s;
		// register reads and their side effects
		if (st_r.rv && RREADY_I)
			st_nxt.rv = 1'b0;
		if (ARVALID_I && ARREADY_O) begin
			st_nxt.rv = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rd = '0;
			case (ARADDR_I & WORD_MASK)
				OFF_CTRL, OFF_TDR, OFF_IER, OFF_IDR: ;
				OFF_MR: st_nxt.rd = st_r.mr;
				OFF_RDR: begin
					st_nxt.rd = st_r.rdr;
					st_nxt.rxf = 1'b0;
				end
				OFF_SR: begin
					st_nxt.rd = sr_v;
					st_nxt.mode_fault = 1'b0;
					st_nxt.ovr = 1'b0;
				end
				OFF_IMR: st_nxt.rd = 32'(st_r.imr);
				OFF_RPR: st_nxt.rd = st_r.rpr;
				OFF_RCR: st_nxt.rd = 32'(st_r.rcr);
				OFF_TPR: st_nxt.rd = st_r.tpr;
				OFF_TCR: st_nxt.rd = 32'(st_r.tcr);
				default: begin
					if ((ARADDR_I & CSR_BANK_MASK) == OFF_CSR0)
						st_nxt.rd = st_r.csr[ARADDR_I[3:2]];
					else
						st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		// register writes, once address and data are both held
		if (st_r.bv && BREADY_I)
			st_nxt.bv = 1'b0;
		if (AWVALID_I && AWREADY_O) begin
			st_nxt.awv = 1'b1;
			st_nxt.awa = AWADDR_I;
		end
		if (WVALID_I && WREADY_O) begin
			st_nxt.wv = 1'b1;
			st_nxt.wd = WDATA_I;
			st_nxt.ws = WSTRB_I;
		end
		if (st_r.awv && st_r.wv) begin
			st_nxt.awv = 1'b0;
			st_nxt.wv = 1'b0;
			st_nxt.bv = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.awa & WORD_MASK)
				OFF_RDR, OFF_SR, OFF_IMR: ;
				OFF_CTRL: begin
					// disable wins over enable in the same write
					if (wdat[CR_DIS]) begin
						if (st_r.mr[MR_MASTER_SELECT] && st_r.st != S_IDLE)
							st_nxt.dis_pend = 1'b1;
						else begin
							st_nxt.en = 1'b0;
							st_nxt.txe = 1'b0;
						end
					end else if (wdat[CR_EN]) begin
						st_nxt.en = 1'b1;
						st_nxt.txe = 1'b1;
					end
				end
				OFF_MR: st_nxt.mr = merge(st_r.mr, st_r.wd, st_r.ws);
				OFF_TDR: begin
					st_nxt.tdr = merge(st_r.tdr, st_r.wd, st_r.ws);
					st_nxt.txe = 1'b0;
				end
				OFF_IER: st_nxt.imr = st_r.imr | wdat[NSRC-1:0];
				OFF_IDR: st_nxt.imr = st_r.imr & ~wdat[NSRC-1:0];
				OFF_RPR: st_nxt.rpr = merge(st_r.rpr, st_r.wd, st_r.ws);
				OFF_RCR: st_nxt.rcr = 16'(merge(32'(st_r.rcr), st_r.wd,
					st_r.ws));
				OFF_TPR: st_nxt.tpr = merge(st_r.tpr, st_r.wd, st_r.ws);
				OFF_TCR: st_nxt.tcr = 16'(merge(32'(st_r.tcr), st_r.wd,
					st_r.ws));
				default: begin
					if ((st_r.awa & CSR_BANK_MASK) == OFF_CSR0)
						st_nxt.csr[st_r.awa[3:2]] = merge(
							st_r.csr[st_r.awa[3:2]], st_r.wd, st_r.ws);
					else
						st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		// buffer channels; an acknowledge is one word moved
		if (RX_ACK_I && RX_REQ_O) begin
			st_nxt.rcr = st_r.rcr - 16'h0001;
			st_nxt.rpr = st_r.rpr + PTR_STEP;
			st_nxt.rxf = 1'b0;
		end
		if (TX_ACK_I && TX_REQ_O) begin
			st_nxt.tcr = st_r.tcr - 16'h0001;
			st_nxt.tpr = st_r.tpr + PTR_STEP;
			st_nxt.tdr = TX_DATA_I;
			st_nxt.txe = 1'b0;
		end
		// serial engine; its flag sets come last so they beat clears
		st_nxt.div = st_r.div + 5'h01;
		st_nxt.nss_q = nss_s;
		st_nxt.sck_q = sck_s;
		if (mtick && st_r.dly != '0)
			st_nxt.dly = st_r.dly - 14'h0001;
		if (!st_r.en) begin
			st_nxt.st = S_IDLE;
			st_nxt.cs = CS_IDLE;
			st_nxt.sclk = tgt_cfg[CSR_POL];
		end else if (st_r.mr[MR_MASTER_SELECT]) begin
			// own drive of line 0 low would read back as a fault
			if (!nss_s && st_r.cs[0]) begin
				st_nxt.mode_fault = 1'b1;
				st_nxt.en = 1'b0;
				st_nxt.txe = 1'b0;
				st_nxt.st = S_IDLE;
				st_nxt.cs = CS_IDLE;
			end else begin
				din = st_r.mr[MR_LLB] ? st_r.tsh[DATA_W-1] : miso_s;
				unique case (st_r.st)
					S_IDLE: begin
						st_nxt.sclk = tgt_cfg[CSR_POL];
						if (st_r.dis_pend) begin
							st_nxt.en = 1'b0;
							st_nxt.txe = 1'b0;
							st_nxt.dis_pend = 1'b0;
						end else if (!st_r.txe && tgt_ok) begin
							st_nxt = load_word(st_nxt, BITS_BASE +
								5'(tgt_cfg[CSR_BITS_LO +: 4]));
							st_nxt.cfg = tgt_cfg;
							st_nxt.cur = tgt_lines;
							st_nxt.sclk = tgt_cfg[CSR_POL];
							st_nxt.st = S_GAP;
							st_nxt.dly = 14'(gap_f <= MIN_GAP ? MIN_GAP
								: gap_f);
						end
					end
					S_GAP: begin
						if (dly_end) begin
							st_nxt.cs = st_r.cur;
							st_nxt.st = S_LEAD;
							// half a serial period is one divider count
							st_nxt.dly = 14'(lead_f == '0 ?
								st_r.cfg[CSR_BAUD_LO +: 8] : lead_f);
						end
					end
					S_LEAD: begin
						if (dly_end) begin
							st_nxt.st = S_XFER;
							st_nxt.hcnt = st_r.cfg[CSR_BAUD_LO +: 8];
						end
					end
					S_XFER: begin
						if (mtick) begin
							if (st_r.hcnt <= 8'h01) begin
								edge_ev = 1'b1;
								st_nxt.hcnt = st_r.cfg[CSR_BAUD_LO +: 8];
								st_nxt.sclk = !st_r.sclk;
							end else
								st_nxt.hcnt = st_r.hcnt - 8'h01;
						end
					end
					S_TAIL: begin
						if (dly_end) begin
							st_nxt = store_word(st_nxt, st_r.cs);
							if (!st_r.txe && tgt_ok && !st_r.dis_pend &&
								tgt_lines == st_r.cur) begin
								st_nxt = load_word(st_nxt, nb);
								st_nxt.hcnt = st_r.cfg[CSR_BAUD_LO +: 8];
								st_nxt.st = S_XFER;
							end else begin
								st_nxt.cs = CS_IDLE;
								st_nxt.st = S_IDLE;
							end
						end
					end
				endcase
			end
		end else begin
			st_nxt.st = S_IDLE;
			st_nxt.cs = CS_IDLE;
			if (st_r.nss_q && !nss_s) begin
				st_nxt.rsh = '0;
				st_nxt.edges = '0;
				if (!st_r.txe)
					st_nxt = load_word(st_nxt, nb);
			end else if (!nss_s && sck_s != st_r.sck_q)
				edge_ev = 1'b1;
		end
		if (edge_ev) begin
			lead_e = !st_r.edges[0];
			samp = cfg_a[CSR_PHA] ? lead_e : !lead_e;
			if (samp)
				st_nxt.rsh = {st_r.rsh[DATA_W-2:0], din};
			else if (cfg_a[CSR_PHA] || st_r.edges != '0)
				st_nxt.tsh = st_r.tsh << 1;
			st_nxt.edges = st_r.edges + 6'h01;
			if (st_r.edges == {nb, 1'b0} - 6'h01) begin
				if (st_r.mr[MR_MASTER_SELECT]) begin
					st_nxt.st = S_TAIL;
					st_nxt.dly = iw_f == '0 ? IW_ZERO
						: 14'({iw_f, 5'h00});
				end else begin
					st_nxt = store_word(st_nxt, '0);
					st_nxt.edges = '0;
					if (!st_r.txe)
						st_nxt = load_word(st_nxt, nb);
				end
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_r <= '0;
			st_r.st <= S_IDLE;
			st_r.cs <= CS_IDLE;
			st_r.nss_q <= 1'b1;
			st_r.sck_q <= 1'b1;
		end else
			st_r <= st_nxt;
	end

	assign AWREADY_O = !st_r.awv && !st_r.bv;
	assign WREADY_O = !st_r.wv && !st_r.bv;
	assign BVALID_O = st_r.bv;
	assign BRESP_O = st_r.bresp;
	assign ARREADY_O = !st_r.rv;
	assign RVALID_O = st_r.rv;
	assign RDATA_O = st_r.rd;
	assign RRESP_O = st_r.rresp;
	assign SERIAL_CLOCK_LINE_O = st_r.sclk;
	assign SERIAL_CLOCK_LINE_OE_O = st_r.en && st_r.mr[MR_MASTER_SELECT];
	assign MOSI_O = st_r.tsh[DATA_W-1];
	assign MOSI_OE_O = st_r.en && st_r.mr[MR_MASTER_SELECT];
	assign MISO_O = st_r.tsh[DATA_W-1];
	assign MISO_OE_O = st_r.en && !st_r.mr[MR_MASTER_SELECT] && !nss_s;
	assign CS_O = st_r.cs;
	assign CS_OE_O = st_r.en && st_r.mr[MR_MASTER_SELECT];
	assign RX_REQ_O = st_r.rxf && st_r.rcr != '0;
	assign TX_REQ_O = st_r.en && st_r.txe && st_r.tcr != '0;
	assign RX_DATA_O = st_r.rdr;
	assign RX_ADDR_O = st_r.rpr;
	assign TX_ADDR_O = st_r.tpr;
	assign IRQ_O = |(sr_v[NSRC-1:0] & st_r.imr);
endmodule

// ===== test/spi_ctrl_assertions.sv
`timescale 1ns/10ps
module spi_ctrl_assertions (
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic [1:0] BRESP_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [spi_pkg::DW-1:0] RDATA_O,
	input wire logic [1:0] RRESP_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic SERIAL_CLOCK_LINE_O,
	input wire logic SERIAL_CLOCK_LINE_OE_O,
	input wire logic MISO_OE_O,
	input wire logic NSS_I,
	input wire logic [3:0] CS_O,
	input wire logic CS_OE_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	chk_sel_gap: assert property (
		$rose(&CS_O) |-> (&CS_O) [*6])
		else $error("select reasserted too soon");
	chk_tail_hold: assert property (
		$changed(SERIAL_CLOCK_LINE_O) && CS_O != 4'hf |-> (CS_O != 4'hf) [*4])
		else $error("select released inside tail delay");
	chk_lead_gap: assert property (
		$changed(CS_O) && CS_O != 4'hf |-> $stable(SERIAL_CLOCK_LINE_O))
		else $error("clock moved with select");
	chk_role_excl: assert property (
		SERIAL_CLOCK_LINE_OE_O |-> !MISO_OE_O)
		else $error("master drives slave output");
	chk_fault_off: assert property (
		(!NSS_I && CS_OE_O && CS_O == 4'hf) [*4] |-> ##[0:3] !CS_OE_O)
		else $error("mode fault did not disable");
	chk_b_hold: assert property (
		BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped");
	chk_r_hold: assert property (
		RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped");
	chk_ar_block: assert property (
		RVALID_O |-> !ARREADY_O)
		else $error("read address taken while busy");
	chk_rd_latency: assert property (
		ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");
	chk_wr_latency: assert property (
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
		else $error("write answer late");

	cover property ($fell(&CS_O));
	cover property ($fell(CS_OE_O));
	cover property (RVALID_O && RRESP_O == 2'h2);
endmodule

bind spi_ctrl spi_ctrl_assertions i_chk (.REF_CLK_I(REF_CLK_I),
	.RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
	.WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
	.BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
	.ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
	.RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .SERIAL_CLOCK_LINE_O(SERIAL_CLOCK_LINE_O),
	.SERIAL_CLOCK_LINE_OE_O(SERIAL_CLOCK_LINE_OE_O), .MISO_OE_O(MISO_OE_O), .NSS_I(NSS_I),
	.CS_O(CS_O), .CS_OE_O(CS_OE_O));

// ===== test/spi_peer_model.sv
`timescale 1ns/10ps
module spi_peer_model (
	input wire logic sck_i,
	input wire logic cs_b_i,
	input wire logic mosi_i,
	input wire logic [7:0] load_i,
	output logic miso_o
);
	logic [7:0] sh_r = 8'h00;
	logic [7:0] got_r = 8'h00;
	// first bit must sit on the line before the leading edge
	always @(negedge cs_b_i) sh_r <= load_i;
	always @(posedge sck_i) if (!cs_b_i) got_r <= {got_r[6:0], mosi_i};
	always @(negedge sck_i) if (!cs_b_i) sh_r <= {sh_r[6:0], ~sh_r[7]};
	// released line shows the inverse so a stale sample cannot pass
	assign miso_o = cs_b_i ? ~sh_r[7] : sh_r[7];
endmodule

// ===== test/spi_ctrl_test.sv
`timescale 1ns/10ps
module spi_ctrl_test;
	import spi_pkg::*;
	logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic slave_select_input = 1, rack = 0, tack = 0, slv = 0, m_sck = 0, m_mosi = 0;
	logic [7:0] awa = 0, ara = 0, ld = 0, rnd = 8'h2c, t, sg;
	logic [31:0] wd = 0, d, tdat = 0;
	logic [5:0] em = 0;
	logic [3:0] c, csv;
	logic [1:0] r;
	int checks = 0, n_fail = 0;
	wire aw_rdy, w_rdy, bv, ar_rdy, rv, sck_o, sck_oe, mo, moe, mi_o, mi_oe;
	wire cs_oe, irq, miso_m, rreq, treq;
	wire [1:0] br, rr;
	wire [31:0] rdat, rxd, rxa, txa;
	wire [3:0] cs;
	// released lines show the inverse, unless the bench is the master
	wire sck_w = sck_oe ? sck_o : (slv ? m_sck : ~sck_o);
	wire mosi_w = moe ? mo : (slv ? m_mosi : ~mo);
	wire miso_w = mi_oe ? mi_o : miso_m;
	wire csb = cs_oe ? &cs : 1'b1;

	always #20 clk = ~clk;

	spi_ctrl i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awa),
		.AWVALID_I(awv), .AWREADY_O(aw_rdy), .WDATA_I(wd), .WSTRB_I(4'hf),
		.WVALID_I(wv), .WREADY_O(w_rdy), .BRESP_O(br), .BVALID_O(bv),
		.BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(ar_rdy),
		.RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre),
		.SERIAL_CLOCK_LINE_I(sck_w), .SERIAL_CLOCK_LINE_O(sck_o), .SERIAL_CLOCK_LINE_OE_O(sck_oe), .MOSI_I(mosi_w),
		.MOSI_O(mo), .MOSI_OE_O(moe), .MISO_I(miso_w), .MISO_O(mi_o),
		.MISO_OE_O(mi_oe), .NSS_I(slave_select_input), .CS_O(cs), .CS_OE_O(cs_oe),
		.RX_REQ_O(rreq), .RX_ACK_I(rack), .RX_DATA_O(rxd), .RX_ADDR_O(rxa),
		.TX_REQ_O(treq), .TX_ACK_I(tack), .TX_DATA_I(tdat), .TX_ADDR_O(txa),
		.IRQ_O(irq));

	spi_peer_model i_peer (.sck_i(sck_w), .cs_b_i(csb), .mosi_i(mosi_w),
		.load_i(ld), .miso_o(miso_m));

	function logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function logic [3:0] sel_lines(input logic [3:0] code);
		for (int j = 0; j < 4; j++) if (!code[j]) return ~(4'h1 << j);
		return 4'hf;
	endfunction

	task summarize;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task tmo;
		n_fail++;
		summarize;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		// spare edge keeps the last release apart from the next request
		@(posedge clk);
		awa <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (aw_rdy) awv <= 0;
			if (w_rdy) wv <= 0;
			if (bv === 1'b1) break;
		end
		if (bv !== 1'b1) tmo();
		r = br;
		bre <= 0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		@(posedge clk);
		ara <= a; arv <= 1; rre <= 1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ar_rdy) arv <= 0;
			if (rv === 1'b1) break;
		end
		if (rv !== 1'b1) tmo();
		v = rdat; e = rr; rre <= 0;
	endtask

	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(d, e);
	endtask

	// one word; waits for the select to drop and to come back
	task xfer(input logic [7:0] tx, input logic [7:0] rx, input logic [3:0] cd);
		ld <= rx;
		wr(OFF_TDR, {12'h0, cd, 8'h0, tx});
		wait_xfer();
	endtask

	task wait_xfer;
		for (int i = 0; i < 400 && cs === 4'hf; i++) @(posedge clk);
		csv = cs;
		for (int i = 0; i < 800 && cs !== 4'hf; i++) @(posedge clk);
		if (cs !== 4'hf) tmo();
	endtask

	task set_csr(input logic [31:0] v);
		for (int k = 0; k < 4; k++) wr(OFF_CSR0 + 8'(4 * k), v);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		rc(OFF_SR, 32'h30);
		rc(OFF_IMR, 32'h0);
		repeat (4) begin
			rnd = nx(rnd);
			wr(OFF_IER, {26'h0, rnd[5:0]});
			em = em | rnd[5:0];
			rnd = nx(rnd);
			wr(OFF_IDR, {26'h0, rnd[5:0]});
			em = em & ~rnd[5:0];
			rc(OFF_IMR, {26'h0, em});
			chk(32'(irq), 32'(|(em & 6'h30)));
		end
		rd(8'h40, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h40, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(OFF_IDR, 32'h3f);
		// phase 1, eight bits, divider 4 for margin on the sampled input
		set_csr(32'h0000_0402);
		wr(OFF_CTRL, 32'h1);
		rc(OFF_SR, 32'h1_0032);
		for (int k = 0; k < 4; k++) begin
			rnd = nx(rnd);
			c = rnd[3:0];
			c[k] = 1'b0;
			for (int j = 0; j < k; j++) c[j] = 1'b1;
			wr(OFF_MR, {12'h0, c, 16'h0001});
			rnd = nx(rnd);
			t = rnd;
			rnd = nx(rnd);
			xfer(t, rnd, 4'h0);
			chk(32'(csv), 32'(sel_lines(c)));
			chk(32'(i_peer.got_r), 32'(t));
			rc(OFF_RDR, {12'h0, sel_lines(c), 8'h0, rnd});
		end
		wr(OFF_MR, 32'h3);
		xfer(8'h5a, 8'h81, 4'hb);
		chk(32'(csv), 32'(sel_lines(4'hb)));
		xfer(8'hc3, 8'h18, 4'hb);
		rc(OFF_SR, 32'h1_003b);
		rc(OFF_SR, 32'h1_0033);
		rc(OFF_RDR, {12'h0, 4'hb, 8'h0, 8'h18});
		rc(OFF_SR, 32'h1_0032);
		wr(OFF_MR, 32'h83);
		xfer(8'h3c, 8'hc0, 4'hb);
		rc(OFF_RDR, {12'h0, 4'hb, 8'h0, 8'h3c});
		wr(OFF_MR, 32'h87);
		xfer(8'h69, 8'h00, 4'h6);
		chk(32'(csv), 32'h6);
		rc(OFF_RDR, {12'h0, 4'h6, 8'h0, 8'h69});
		wr(OFF_IER, 32'h1);
		xfer(8'h00, 8'h00, 4'hb);
		chk(32'(irq), 32'h1);
		rd(OFF_RDR, d, r);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		// buffer channels: one transmit move starts a word, one receive move
		wr(OFF_RPR, 32'h100);
		wr(OFF_RCR, 32'h2);
		wr(OFF_TPR, 32'h200);
		wr(OFF_TCR, 32'h1);
		chk(32'(treq), 32'h1);
		tdat <= {12'h0, 4'hb, 8'h0, 8'h96};
		tack <= 1;
		@(posedge clk);
		tack <= 0;
		wait_xfer();
		chk(txa, 32'h200 + PTR_STEP);
		chk(32'(treq), 32'h0);
		chk(32'(rreq), 32'h1);
		chk(rxd, {12'h0, 4'hb, 8'h0, 8'h96});
		chk(rxa, 32'h100);
		rack <= 1;
		@(posedge clk);
		rack <= 0;
		rc(OFF_RCR, 32'h1);
		rc(OFF_RPR, 32'h100 + PTR_STEP);
		rc(OFF_SR, 32'h1_0022);
		wr(OFF_RCR, 32'h0);
		slave_select_input <= 0;
		repeat (6) @(posedge clk);
		slave_select_input <= 1;
		repeat (4) @(posedge clk);
		rc(OFF_SR, 32'h34);
		rc(OFF_SR, 32'h30);
		// idle level one and a stopped divider
		set_csr(32'h0000_0003);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_TDR, 32'h0000_00a5);
		repeat (100) @(posedge clk);
		chk(32'(sck_o), 32'h1);
		rc(OFF_SR, 32'h1_0030);
		wr(OFF_CTRL, 32'h3);
		rc(OFF_SR, 32'h30);
		chk(32'(sck_oe), 32'h0);
		// slave: the bench is the outside master, phase 1, idle low
		slv <= 1;
		wr(OFF_MR, 32'h0);
		set_csr(32'h0000_0402);
		wr(OFF_CTRL, 32'h1);
		rnd = nx(rnd);
		t = rnd;
		wr(OFF_TDR, {24'h0, t});
		rnd = nx(rnd);
		slave_select_input <= 0;
		repeat (6) @(posedge clk);
		for (int b = 7; b >= 0; b--) begin
			m_mosi <= rnd[b];
			repeat (4) @(posedge clk);
			sg = {sg[6:0], miso_w};
			m_sck <= 1;
			repeat (4) @(posedge clk);
			m_sck <= 0;
		end
		repeat (6) @(posedge clk);
		slave_select_input <= 1;
		chk(32'(sck_oe), 32'h0);
		chk(32'(sg), 32'(t));
		rc(OFF_RDR, {24'h0, rnd});
		summarize;
	end
endmodule
